// File: pscl_defines.vh
/*
 * Register offsets, field positions, reset values and strap defaults
 * for the strap capture block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PSCL_DEFINES_VH
`define PSCL_DEFINES_VH

// ****************************************
// Register offsets (5-bit register index)
// ****************************************
`define PSCL_REG_BMCR     5'h00
`define PSCL_REG_ANAR     5'h04
`define PSCL_REG_STRAP    5'h1f

// ****************************************
// Basic control register fields
// ****************************************
`define PSCL_BMCR_RESET   15
`define PSCL_BMCR_LOOP    14
`define PSCL_BMCR_SPEED   13
`define PSCL_BMCR_ANEN    12
`define PSCL_BMCR_PDOWN   11
`define PSCL_BMCR_ISO     10
`define PSCL_BMCR_RESTART 9
`define PSCL_BMCR_DUPLEX  8
`define PSCL_BMCR_WMASK   16'hff80

// ****************************************
// Advertisement register fields
// ****************************************
`define PSCL_ANAR_100FD   8
`define PSCL_ANAR_100HD   7
`define PSCL_ANAR_10FD    6
`define PSCL_ANAR_10HD    5
`define PSCL_ANAR_SEL     16'h0001
`define PSCL_ANAR_WMASK   16'hffe0

// ****************************************
// Strap status register fields
// ****************************************
`define PSCL_STR_SPEED    0
`define PSCL_STR_DUPLEX   1
`define PSCL_STR_ANEN     2
`define PSCL_STR_ISO      3
`define PSCL_STR_BCOFF    4
`define PSCL_STR_DONE     5

// ****************************************
// Strap defaults held while in reset
// ****************************************
`define PSCL_DEF_SPEED    1'b1
`define PSCL_DEF_DUPLEX   1'b1
`define PSCL_DEF_ANEN     1'b1
`define PSCL_DEF_ISO      1'b0
`define PSCL_DEF_BCOFF    1'b0

// ****************************************
// Register values before the capture
// ****************************************
`define PSCL_BMCR_RST     16'h3000
`define PSCL_ANAR_RST     16'h01e1

`endif

// File: pscl_capture.v
/*
 * One-shot strap capture: samples the strap pins once, on the first
 * clock edge after reset release, then holds them until the next reset.
 * Assumes strap inputs are synchronous to i_clk and stable at release.
 */
`timescale 1ns/1ps
`include "pscl_defines.vh"

module pscl_capture (
   input  wire       i_clk,      // Device clock.
   input  wire       i_rst_n,    // Asynchronous reset, active low.
   input  wire [4:0] i_straps,   // Strap pins {bcoff, iso, anen, duplex, speed}.
   output reg  [4:0] o_straps,   // Captured strap levels.
   output reg        o_load,     // One-cycle pulse when the capture happens.
   output reg        o_done      // High once captured.
);

   // ****************************************
   // Capture
   // ****************************************
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_straps <= {`PSCL_DEF_BCOFF, `PSCL_DEF_ISO, `PSCL_DEF_ANEN, `PSCL_DEF_DUPLEX, `PSCL_DEF_SPEED};
         o_load   <= 1'b0;
         o_done   <= 1'b0;
      end else begin
         o_load <= 1'b0;
         if (!o_done) begin
            o_straps <= i_straps;
            o_load   <= 1'b1;
            o_done   <= 1'b1;
         end
      end
   end

endmodule

// File: pscl_strap_latch.v
/*
 * Strap-in configuration loader of a 10/100 transceiver. Captures strap
 * levels at reset release and seeds the basic control register, the
 * advertisement register and the address-0 broadcast setting.
 * Assumes a register port with a one-cycle read latency driven by the
 * management logic, and strap pins stable around reset release.
 */
// Functional notes
// - Speed strap sampled at release loads control bit 13; high means 100Mbps.
// - Sampled speed strap also sets advertised speed capability bits in register 4h.
// - Duplex strap sampled at release loads control bit 8; high means half duplex.
// - Autoneg enable strap sampled at release loads control bit 12; high enables.
// - Broadcast disable strap high makes address 0 an ordinary unique address.
// - Isolate strap sampled at release loads control bit 10; high isolates.
// - Broadcast disable strap low, the default, makes address 0 a broadcast address.
`timescale 1ns/1ps
`include "pscl_defines.vh"

module pscl_strap_latch (
   input  wire        i_clk,                        // 125 MHz device clock.
   input  wire        i_rst_n,                      // Asynchronous reset, active low.
   input  wire        i_speed_strap,                // Speed strap level.
   input  wire        i_duplex_strap,               // Duplex strap level.
   input  wire        i_autoneg_enable_strap,       // Auto-negotiation enable strap level.
   input  wire        i_isolate_strap,              // Isolate strap level.
   input  wire        i_broadcast_disable_strap,    // Address-0 broadcast disable strap level.
   input  wire [4:0]  i_mgmt_phy_addr,              // Management address of current frame.
   input  wire [4:0]  i_own_phy_addr,               // This device's management address.
   input  wire [4:0]  i_reg_addr,                   // Register index.
   input  wire [15:0] i_reg_wdata,                  // Register write data.
   input  wire        i_reg_wr,                     // Register write strobe.
   input  wire        i_reg_rd,                     // Register read strobe.
   output reg  [15:0] o_reg_rdata,                  // Read data, valid the cycle after the strobe.
   output reg         o_speed_100,                  // Selected speed is 100Mbps.
   output reg         o_full_duplex,                // Selected duplex is full.
   output reg         o_autoneg_en,                 // Auto-negotiation enabled.
   output reg         o_isolate,                    // MAC interface isolated.
   output reg         o_bcast_addr0,                // Address 0 acts as broadcast.
   output reg         o_addr_match                  // Current management address selects this device.
);

   // ****************************************
   // Strap capture
   // ****************************************
   wire [4:0] straps_w;
   wire       load_w;
   wire       done_w;

   pscl_capture u_capture (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_straps ({i_broadcast_disable_strap, i_isolate_strap, i_autoneg_enable_strap,
                  i_duplex_strap, i_speed_strap}),
      .o_straps (straps_w),
      .o_load   (load_w),
      .o_done   (done_w)
   );

   // ****************************************
   // Decode helpers
   // ****************************************
   function [3:0] pscl_adv_speed;
      input speed_100;
      begin
         if (speed_100) begin
            pscl_adv_speed = 4'hf;
         end else begin
            pscl_adv_speed = 4'h3;
         end
      end
   endfunction

   function pscl_hit;
      input [4:0] addr;
      input [4:0] idx;
      begin
         pscl_hit = (addr == idx);
      end
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   reg [15:0] bmcr_q;
   reg [15:0] bmcr_d;
   reg [15:0] anar_q;
   reg [15:0] anar_d;
   reg        bcoff_q;
   reg        bcoff_d;

   always @* begin
      bmcr_d  = bmcr_q;
      anar_d  = anar_q;
      bcoff_d = bcoff_q;
      if (load_w) begin
         bmcr_d[`PSCL_BMCR_SPEED]  = straps_w[`PSCL_STR_SPEED];
         bmcr_d[`PSCL_BMCR_DUPLEX] = ~straps_w[`PSCL_STR_DUPLEX];
         bmcr_d[`PSCL_BMCR_ANEN]   = straps_w[`PSCL_STR_ANEN];
         bmcr_d[`PSCL_BMCR_ISO]    = straps_w[`PSCL_STR_ISO];
         anar_d[`PSCL_ANAR_100FD:`PSCL_ANAR_10HD] = pscl_adv_speed(straps_w[`PSCL_STR_SPEED]);
         bcoff_d = straps_w[`PSCL_STR_BCOFF];
      end else if (i_reg_wr && done_w) begin
         // Management writes may override strapped values after capture.
         if (pscl_hit(i_reg_addr, `PSCL_REG_BMCR)) begin
            bmcr_d = i_reg_wdata & `PSCL_BMCR_WMASK;
            bmcr_d[`PSCL_BMCR_RESET]   = 1'b0;
            bmcr_d[`PSCL_BMCR_RESTART] = 1'b0;
         end
         if (pscl_hit(i_reg_addr, `PSCL_REG_ANAR)) begin
            anar_d = (i_reg_wdata & `PSCL_ANAR_WMASK) | `PSCL_ANAR_SEL;
         end
         if (pscl_hit(i_reg_addr, `PSCL_REG_STRAP)) begin
            bcoff_d = i_reg_wdata[`PSCL_STR_BCOFF];
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bmcr_q  <= `PSCL_BMCR_RST;
         anar_q  <= `PSCL_ANAR_RST;
         bcoff_q <= 1'b0;
      end else begin
         bmcr_q  <= bmcr_d;
         anar_q  <= anar_d;
         bcoff_q <= bcoff_d;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         if (pscl_hit(i_reg_addr, `PSCL_REG_BMCR)) begin
            o_reg_rdata <= bmcr_q;
         end else if (pscl_hit(i_reg_addr, `PSCL_REG_ANAR)) begin
            o_reg_rdata <= anar_q;
         end else if (pscl_hit(i_reg_addr, `PSCL_REG_STRAP)) begin
            o_reg_rdata <= {10'h000, done_w, bcoff_q, straps_w[3:0]};
         end else begin
            o_reg_rdata <= 16'h0000;
         end
      end else begin
         o_reg_rdata <= 16'h0000;
      end
   end

   // ****************************************
   // Mode outputs and address match
   // ****************************************
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_speed_100   <= 1'b0;
         o_full_duplex <= 1'b0;
         o_autoneg_en  <= 1'b0;
         o_isolate     <= 1'b0;
         o_bcast_addr0 <= 1'b0;
         o_addr_match  <= 1'b0;
      end else begin
         o_speed_100   <= bmcr_d[`PSCL_BMCR_SPEED];
         o_full_duplex <= bmcr_d[`PSCL_BMCR_DUPLEX];
         o_autoneg_en  <= bmcr_d[`PSCL_BMCR_ANEN];
         o_isolate     <= bmcr_d[`PSCL_BMCR_ISO];
         o_bcast_addr0 <= ~bcoff_d;
         // Address 0 is broadcast unless disabled; then it is an ordinary address.
         o_addr_match  <= pscl_hit(i_mgmt_phy_addr, i_own_phy_addr) ||
                          (pscl_hit(i_mgmt_phy_addr, 5'h00) && !bcoff_d);
      end
   end

endmodule

// File: pscl_strap_latch_assertions.sv
/* Checker for the strap capture block.
   Assumes it is bound to pscl_strap_latch. */
`timescale 1ns/1ps
`include "pscl_defines.vh"
module pscl_strap_latch_chk (
   input wire        i_clk,                     // Clock.
   input wire        i_rst_n,                   // Reset.
   input wire        i_speed_strap,             // Strap.
   input wire        i_duplex_strap,            // Strap.
   input wire        i_autoneg_enable_strap,    // Strap.
   input wire        i_isolate_strap,           // Strap.
   input wire        i_broadcast_disable_strap, // Strap.
   input wire [4:0]  i_mgmt_phy_addr,           // Address.
   input wire [4:0]  i_own_phy_addr,            // Address.
   input wire [4:0]  i_reg_addr,                // Index.
   input wire [15:0] i_reg_wdata,               // Data.
   input wire        i_reg_wr,                  // Strobe.
   input wire        i_reg_rd,                  // Strobe.
   input wire [15:0] o_reg_rdata,               // Data.
   input wire        o_speed_100,               // Mode.
   input wire        o_full_duplex,             // Mode.
   input wire        o_autoneg_en,              // Mode.
   input wire        o_isolate,                 // Mode.
   input wire        o_bcast_addr0,             // Mode.
   input wire        o_addr_match               // Match.
);
   reg [1:0] cnt_q;
   reg [4:0] st_q;
   reg       adv_wr_q;
   wire [4:0] mode = {o_bcast_addr0, o_isolate, o_autoneg_en, o_full_duplex, o_speed_100};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 2'h0;
      end else if (cnt_q != 2'h3) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
   // Marks a software write to the advertisement register since reset.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adv_wr_q <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == `PSCL_REG_ANAR) begin
         adv_wr_q <= 1'b1;
      end
   end
   // Straps seen on the first edge after release, as the block should see them.
   always @(posedge i_clk) begin
      if (cnt_q == 2'h0) begin
         st_q <= {i_broadcast_disable_strap, i_isolate_strap, i_autoneg_enable_strap, i_duplex_strap, i_speed_strap};
      end
   end
   sequence s_adv_rd;
      i_reg_rd && i_reg_addr == `PSCL_REG_ANAR;
   endsequence
   chk_speed_capture: assert property (cnt_q == 2'h2 |-> o_speed_100 == st_q[0]) else $error("speed");
   chk_duplex_capture: assert property (cnt_q == 2'h2 |-> o_full_duplex == !st_q[1]) else $error("duplex");
   chk_anen_capture: assert property (cnt_q == 2'h2 |-> o_autoneg_en == st_q[2]) else $error("autoneg");
   chk_iso_capture: assert property (cnt_q == 2'h2 |-> o_isolate == st_q[3]) else $error("isolate");
   chk_bcast_capture: assert property (cnt_q == 2'h2 |-> o_bcast_addr0 == !st_q[4]) else $error("bcast");
   chk_straps_ignored: assert property (cnt_q == 2'h3 && !i_reg_wr |=> $stable(mode)) else $error("mode moved");
   chk_adv_select: assert property (s_adv_rd |=> o_reg_rdata[4:0] == 5'h01) else $error("adv");
   chk_adv_speed: assert property (s_adv_rd ##0 (cnt_q == 2'h3 && !adv_wr_q) |=>
      o_reg_rdata[8:5] == (st_q[0] ? 4'hf : 4'h3)) else $error("adv speed");
   chk_addr_match: assert property (cnt_q == 2'h3 |=> o_addr_match ==
      ($past(i_mgmt_phy_addr) == $past(i_own_phy_addr) ||
       ($past(i_mgmt_phy_addr) == 5'h00 && o_bcast_addr0))) else $error("match");
endmodule
bind pscl_strap_latch pscl_strap_latch_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_speed_strap(i_speed_strap),
   .i_duplex_strap(i_duplex_strap), .i_autoneg_enable_strap(i_autoneg_enable_strap), .i_isolate_strap(i_isolate_strap),
   .i_broadcast_disable_strap(i_broadcast_disable_strap), .i_mgmt_phy_addr(i_mgmt_phy_addr),
   .i_own_phy_addr(i_own_phy_addr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_speed_100(o_speed_100), .o_full_duplex(o_full_duplex),
   .o_autoneg_en(o_autoneg_en), .o_isolate(o_isolate), .o_bcast_addr0(o_bcast_addr0), .o_addr_match(o_addr_match));

// File: pscl_board.sv
/* Board model: strap pull resistors.
   Assumes unfitted pins fall back to the internal pulls. */
`timescale 1ns/1ps
module pscl_board (
   input  wire [4:0] i_fit,   // Resistor fitted per pin.
   input  wire [4:0] i_level, // Level the fitted resistor pulls to.
   output wire [4:0] o_pins   // {bcoff, iso, anen, duplex, speed}.
);
   // Internal pulls: up on speed, duplex, autoneg; down on isolate, broadcast.
   assign o_pins = (i_fit & i_level) | (~i_fit & 5'h07);
endmodule

// File: testbench.sv
/* Self-checking bench for the strap capture block.
   Assumes the register port and reset timing of the block. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
   logic i_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0;
   logic [4:0] i_reg_addr = 0, i_mgmt_phy_addr = 0, i_own_phy_addr = 5'h01, fit = 0, lvl = 0;
   logic [15:0] i_reg_wdata = 0;
   wire [15:0] o_reg_rdata;
   wire [4:0] pins;
   wire o_speed_100, o_full_duplex, o_autoneg_en, o_isolate, o_bcast_addr0, o_addr_match;
   int err_total = 0, num_checks = 0, cyc = 0;
   logic [4:0] s;
   always #4 i_clk = ~i_clk;
   pscl_board i_board (.i_fit(fit), .i_level(lvl), .o_pins(pins));
   pscl_strap_latch i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_speed_strap(pins[0]), .i_duplex_strap(pins[1]),
      .i_autoneg_enable_strap(pins[2]), .i_isolate_strap(pins[3]), .i_broadcast_disable_strap(pins[4]),
      .i_mgmt_phy_addr(i_mgmt_phy_addr), .i_own_phy_addr(i_own_phy_addr), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .o_speed_100(o_speed_100), .o_full_duplex(o_full_duplex), .o_autoneg_en(o_autoneg_en),
      .o_isolate(o_isolate), .o_bcast_addr0(o_bcast_addr0), .o_addr_match(o_addr_match));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk) begin i_reg_wr <= 1; i_reg_addr <= a; i_reg_wdata <= d; end
      @(posedge i_clk) i_reg_wr <= 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge i_clk) begin i_reg_rd <= 1; i_reg_addr <= a; end
      @(posedge i_clk) i_reg_rd <= 0;
      #1 `CHK("rdata", e, o_reg_rdata)
   endtask
   task automatic chk_modes();
      rd(5'h00, {2'b00, s[0], s[2], 1'b0, s[3], 1'b0, ~s[1], 8'h00});
      rd(5'h04, s[0] ? 16'h01e1 : 16'h0061);
      rd(5'h1f, {10'h000, 1'b1, s});
      `CHK("modes", {~s[4], s[3], s[2], ~s[1], s[0]}, {o_bcast_addr0, o_isolate, o_autoneg_en, o_full_duplex, o_speed_100})
      `CHK("match", ~s[4], o_addr_match)
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      for (int k = 0; k < 2; k++) begin
         @(posedge i_clk) begin i_rst_n <= 0; fit <= k ? 5'h1f : 5'h00; lvl <= 5'h18; i_mgmt_phy_addr <= 5'h00; end
         repeat (4) @(posedge i_clk);
         i_rst_n <= 1;
         s = k ? 5'h18 : 5'h07;
         repeat (3) @(posedge i_clk);
         chk_modes();
         @(posedge i_clk) begin fit <= 5'h1f; lvl <= ~s; end
         repeat (2) @(posedge i_clk);
         chk_modes();
         wr(5'h00, 16'h0100);
         #1 `CHK("full", 1'b1, o_full_duplex)
         `CHK("speed", 1'b0, o_speed_100)
         rd(5'h00, 16'h0100);
         wr(5'h1f, 16'h0010);
         #1 `CHK("bcast", 1'b0, o_bcast_addr0)
         `CHK("addr0", 1'b0, o_addr_match)
         @(posedge i_clk) i_mgmt_phy_addr <= 5'h01;
         rd(5'h0b, 16'h0000);
         `CHK("own", 1'b1, o_addr_match)
         wr(5'h04, 16'h0021);
         rd(5'h04, 16'h0021);
         $display("test %0d done", k);
      end
      stop_test();
   end
endmodule
